// *** src/asf_alert_flags.sv ***
// Latched alert flags for supply, charge pump, temperature and channel
// faults, read and cleared by write-one through the register port.
// Assumes monitor pins are asynchronous; config comes from clock domain.
`timescale 1ns/10ps

// Function
// (R1) Latch digital supply low at bit 8
// (R2) Latch high supply low at bit 7
// (R3) Latch 5 V regulator low at bit 6
// (R4) Latch charge pump fault at bit 5
// (R5) Latch over-temperature at bit 4
// (R6) Channel fault bits 3..0, meaning per function
// (R7) Voltage output short after 2 ms persistence
// (R8) Current output open after 2 ms persistence
// (R9) Loop input short via inverted comparator, user debounce
// (R10) External input overcurrent via comparator, user debounce
// (R11) Reset to zero, read latched, clear by one
// (R12) Software clears with one, zero leaves flag
// (R13) Simultaneous set and clear keeps flag set
module asf_alert_flags
    import asf_pkg::*;
#(
    parameter int OUT_DEBOUNCE_CYC = ASF_OUT_DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire asf_mon_t mon_pins,
    input wire asf_chan_det_t [ASF_NUM_CH-1:0] chan_det_pins,
    input wire asf_chan_cfg_t [ASF_NUM_CH-1:0] chan_cfg,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic [ASF_NUM_FLAGS-1:0] alert_flags
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    asf_mon_t mon_s1_q; // First stage, read only by second
    asf_mon_t mon_s2_q; // Safe monitor levels
    asf_chan_det_t [ASF_NUM_CH-1:0] det_s1_q; // First stage
    asf_chan_det_t [ASF_NUM_CH-1:0] det_s2_q; // Safe detector levels

    // Two flops on every asynchronous pin
    always_ff @(posedge clock) begin
        if (rst) begin
            mon_s1_q <= '0;
            mon_s2_q <= '0;
            det_s1_q <= '0;
            det_s2_q <= '0;
        end else begin
            mon_s1_q <= mon_pins;
            mon_s2_q <= mon_s1_q;
            det_s1_q <= chan_det_pins;
            det_s2_q <= det_s1_q;
        end
    end

    // ==========================================================
    // Channel fault qualifiers
    // ==========================================================
    logic [ASF_NUM_CH-1:0] chan_fault; // Debounced channel faults

    // One qualifier per channel
    for (genvar ch = 0; ch < ASF_NUM_CH; ch++) begin : g_chan
        asf_chan_fault #(
            .OUT_DEBOUNCE_CYC(OUT_DEBOUNCE_CYC)
        ) u_fault (
            .clock(clock),
            .rst(rst),
            .cfg(chan_cfg[ch]),
            .det(det_s2_q[ch]),
            .fault(chan_fault[ch])
        );
    end

    // ==========================================================
    // Flag set and clear
    // ==========================================================
    logic [ASF_NUM_FLAGS-1:0] set_vec; // Events this cycle
    logic [ASF_NUM_FLAGS-1:0] clr_vec; // Write-one clears this cycle
    logic [ASF_NUM_FLAGS-1:0] flags_q; // Latched flags
    logic [ASF_NUM_FLAGS-1:0] flags_d;
    logic [15:0] rdata_q; // Read data holding register
    logic [15:0] rdata_d;
    logic hit; // Access targets the alert register

    assign hit = (reg_addr == ASF_ALERT_ADDR);

    // Gather events and compute next flags
    always_comb begin
        set_vec = '0;
        set_vec[ASF_BIT_DIGITAL_SUPPLY] = mon_s2_q.digital_supply_low; // R1
        set_vec[ASF_BIT_HIGH_SUPPLY] = mon_s2_q.high_supply_low; // R2
        set_vec[ASF_BIT_REGULATOR5] = mon_s2_q.regulator5_low; // R3
        set_vec[ASF_BIT_CHARGE_PUMP] = mon_s2_q.charge_pump_high; // R4
        set_vec[ASF_BIT_OVER_TEMP] = mon_s2_q.over_temperature; // R5
        set_vec[ASF_BIT_CHANNEL0 +: ASF_NUM_CH] = chan_fault; // R6
        // Only ones clear; zeros leave flags alone
        if (reg_wr && hit) begin
            clr_vec = reg_wdata[ASF_NUM_FLAGS-1:0]; // R11 R12
        end else begin
            clr_vec = '0;
        end
        // Set wins over a clear in the same cycle
        flags_d = (flags_q & ~clr_vec) | set_vec; // R13
    end

    // Read data: latched flags, upper bits zero here
    always_comb begin
        if (reg_rd && hit) begin
            rdata_d = '0;
            rdata_d[ASF_NUM_FLAGS-1:0] = flags_q; // R11
        end else if (reg_rd) begin
            rdata_d = '0; // Unknown address reads zero
        end else begin
            rdata_d = rdata_q; // Hold last read
        end
    end

    // Flag and read data registers
    always_ff @(posedge clock) begin
        if (rst) begin
            flags_q <= ASF_ALERT_RESET[ASF_NUM_FLAGS-1:0]; // R11
            rdata_q <= '0;
        end else begin
            flags_q <= flags_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign reg_rdata = rdata_q;
    assign alert_flags = flags_q;

endmodule : asf_alert_flags

// *** src/asf_pkg.sv ***
// Shared constants and carrier types for the alert status flag block.
// Assumes one 200 MHz clock and a synchronous active-high reset.
package asf_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] ASF_ALERT_ADDR = 8'h2e; // Latched alert flags
    localparam logic [15:0] ASF_ALERT_RESET = 16'h0000; // Lower flags reset
    localparam int ASF_NUM_CH = 4; // Channel count

    // Field positions inside the alert register
    localparam int ASF_BIT_DIGITAL_SUPPLY = 8;
    localparam int ASF_BIT_HIGH_SUPPLY = 7;
    localparam int ASF_BIT_REGULATOR5 = 6;
    localparam int ASF_BIT_CHARGE_PUMP = 5;
    localparam int ASF_BIT_OVER_TEMP = 4;
    localparam int ASF_BIT_CHANNEL0 = 0; // Channels 0..3 at bits 0..3
    localparam int ASF_NUM_FLAGS = 9; // Bits 8..0 held here

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int ASF_CLK_PERIOD_PS = 5000; // 200 MHz
    localparam int ASF_OUT_DEBOUNCE_US = 2000; // 2 ms output debounce
    // Least time, so round up to whole cycles
    localparam int ASF_OUT_DEBOUNCE_CYC =
        (ASF_OUT_DEBOUNCE_US * 1000000 + ASF_CLK_PERIOD_PS - 1)
        / ASF_CLK_PERIOD_PS;
    localparam int ASF_CNT_W = 20; // Debounce counter width

    // ==========================================================
    // Channel function codes
    // ==========================================================
    typedef enum logic [3:0] {
        ASF_FUNC_HIGH_Z    = 4'h0,
        ASF_FUNC_VOUT      = 4'h1,
        ASF_FUNC_IOUT      = 4'h2,
        ASF_FUNC_VIN       = 4'h3,
        ASF_FUNC_IIN_EXT   = 4'h4,
        ASF_FUNC_IIN_LOOP  = 4'h5,
        ASF_FUNC_RTD       = 4'h6,
        ASF_FUNC_DIN_LOGIC = 4'h7,
        ASF_FUNC_DIN_LOOP  = 4'h8
    } asf_func_t;

    // Supply and temperature monitor levels (high = fault present)
    typedef struct packed {
        logic digital_supply_low;
        logic high_supply_low;
        logic regulator5_low;
        logic charge_pump_high;
        logic over_temperature;
    } asf_mon_t;

    // Per-channel configuration from the channel setup registers
    typedef struct packed {
        asf_func_t channel_function_select;
        logic comparator_enable;
        logic comparator_output_invert;
        logic [15:0] user_debounce_cycles; // Input comparator config
    } asf_chan_cfg_t;

    // Per-channel analog detector levels (asynchronous)
    typedef struct packed {
        logic vout_short;  // Output short detector
        logic iout_open;   // Output open-circuit detector
        logic comp_raw;    // Input comparator, high above half supply
    } asf_chan_det_t;

endpackage : asf_pkg

// *** src/asf_chan_fault.sv ***
// Per-channel fault qualifier: picks the fault source by function and
// requires it to persist for the debounce length before reporting.
// Assumes detector inputs are already synchronised to clock.
`timescale 1ns/10ps
module asf_chan_fault
    import asf_pkg::*;
#(
    parameter int OUT_DEBOUNCE_CYC = ASF_OUT_DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire asf_chan_cfg_t cfg,
    input wire asf_chan_det_t det,
    output logic fault
);

    // ==========================================================
    // Condition select
    // ==========================================================
    logic cond; // Raw fault condition for the chosen function
    logic [ASF_CNT_W-1:0] limit; // Persistence needed
    logic [ASF_CNT_W-1:0] cnt_q; // Cycles the condition has held
    logic [ASF_CNT_W-1:0] cnt_d;

    // Source and length depend on the channel function
    always_comb begin
        cond = 1'b0;
        limit = ASF_CNT_W'(OUT_DEBOUNCE_CYC);
        unique case (cfg.channel_function_select)
            ASF_FUNC_VOUT: begin
                cond = det.vout_short; // R7
            end
            ASF_FUNC_IOUT: begin
                cond = det.iout_open; // R8
            end
            ASF_FUNC_IIN_LOOP: begin
                // Inverted trip below half supply means short to ground
                cond = cfg.comparator_enable
                       & cfg.comparator_output_invert
                       & ~det.comp_raw; // R9
                limit = ASF_CNT_W'(cfg.user_debounce_cycles); // R9
            end
            ASF_FUNC_IIN_EXT: begin
                // Non-inverted trip means excess source current
                cond = cfg.comparator_enable
                       & ~cfg.comparator_output_invert
                       & det.comp_raw; // R10
                limit = ASF_CNT_W'(cfg.user_debounce_cycles); // R10
            end
            default: begin
                cond = 1'b0; // Other functions raise no channel fault
            end
        endcase
    end

    // ==========================================================
    // Persistence counter
    // ==========================================================
    // Restarts whenever the condition drops; saturates at the limit
    always_comb begin
        if (!cond) begin
            cnt_d = '0;
        end else if (cnt_q < limit) begin
            cnt_d = cnt_q + ASF_CNT_W'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    // Counter register
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Fault once held continuously for the full length (R7, R8)
    assign fault = cond && (cnt_q >= limit) && (limit != '0);

endmodule : asf_chan_fault

// *** dv/asf_alert_flags_chk.sv ***
// Concurrent checks on the alert flag block ports.
// Assumes it is bound to asf_alert_flags with its debounce parameter.
`timescale 1ns/10ps
module asf_alert_flags_chk
    import asf_pkg::*;
#(
    parameter int OUT_DEBOUNCE_CYC = ASF_OUT_DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire asf_mon_t mon_pins,
    input wire asf_chan_det_t [ASF_NUM_CH-1:0] chan_det_pins,
    input wire asf_chan_cfg_t [ASF_NUM_CH-1:0] chan_cfg,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [ASF_NUM_FLAGS-1:0] alert_flags
);
    // ==========================================================
    // Helpers
    logic [8:0] clr; // Bits cleared by this cycle's write
    assign clr = (reg_wr && reg_addr == ASF_ALERT_ADDR) ? reg_wdata[8:0] : '0;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Pin level two edges back is what the synchroniser offers now
    sequence s_temp_held;
        mon_pins.over_temperature ##2 1'b1;
    endsequence
    // ==========================================================
    // Assertions
    chk_dsup_latch: assert property (
        $rose(mon_pins.digital_supply_low) |-> ##[1:3] alert_flags[8])
        else $error("digital supply flag missing");
    chk_hsup_latch: assert property (
        $rose(mon_pins.high_supply_low) |-> ##[1:3] alert_flags[7])
        else $error("high supply flag missing");
    chk_reg5_latch: assert property (
        $rose(mon_pins.regulator5_low) |-> ##[1:3] alert_flags[6])
        else $error("regulator flag missing");
    chk_pump_latch: assert property (
        $rose(mon_pins.charge_pump_high) |-> ##[1:3] alert_flags[5])
        else $error("charge pump flag missing");
    chk_temp_latch: assert property (
        $rose(mon_pins.over_temperature) |-> ##[1:3] alert_flags[4])
        else $error("temperature flag missing");
    chk_reset_zero: assert property (
        $fell(rst) |-> alert_flags == '0 && reg_rdata == 16'h0000)
        else $error("flags not zero after reset");
    chk_flag_sticky: assert property (
        1'b1 |=> (~alert_flags & $past(alert_flags) & ~$past(clr)) == '0)
        else $error("flag dropped without a clear");
    chk_read_data: assert property (
        reg_rd && reg_addr == ASF_ALERT_ADDR
        |=> reg_rdata == {7'h00, $past(alert_flags)})
        else $error("read data differs from flags");
    chk_read_other: assert property (
        reg_rd && reg_addr != ASF_ALERT_ADDR |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_set_wins: assert property (
        s_temp_held ##0 clr[4] |=> alert_flags[4])
        else $error("clear beat a present cause");
    chk_out_debounce: assert property (
        $rose(alert_flags[0])
        && chan_cfg[0].channel_function_select == ASF_FUNC_VOUT
        |-> $past(chan_det_pins[0].vout_short, OUT_DEBOUNCE_CYC))
        else $error("short flagged before debounce");
endmodule : asf_alert_flags_chk

bind asf_alert_flags asf_alert_flags_chk #(
    .OUT_DEBOUNCE_CYC(OUT_DEBOUNCE_CYC)
) i_chk (.clock(clock), .rst(rst), .mon_pins(mon_pins),
    .chan_det_pins(chan_det_pins), .chan_cfg(chan_cfg),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .alert_flags(alert_flags));

// *** dv/asf_alert_flags_tb.sv ***
// Self-checking bench for the alert flag block.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
module asf_alert_flags_tb;
    import asf_pkg::*;
    localparam int L = 16; // Shortened output debounce
    logic clock = 1'b0;
    logic rst = 1'b1;
    asf_mon_t mon = '0;
    asf_chan_det_t [ASF_NUM_CH-1:0] det = '0;
    asf_chan_cfg_t [ASF_NUM_CH-1:0] cfg = '0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [ASF_NUM_FLAGS-1:0] flags;
    logic [15:0] v;
    int err_total = 0;
    int comparisons = 0;
    int seed = 87;
    int n;

    asf_alert_flags #(.OUT_DEBOUNCE_CYC(L)) i_dut (.clock(clock),
        .rst(rst), .mon_pins(mon), .chan_det_pins(det), .chan_cfg(cfg),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
        .reg_rdata(rdata), .alert_flags(flags));

    // 200 MHz clock
    initial begin
        forever #2.5 clock = ~clock;
    end
    // Wait k edges, then step just past the edge
    task automatic step(int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : step
    task automatic cmp(string name, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : cmp
    task automatic wreg(logic [7:0] a, logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
    endtask : wreg
    task automatic rreg(logic [7:0] a, output logic [15:0] d);
        addr = a;
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        step(1);
        d = rdata;
    endtask : rreg
    // Flag mask for monitor i, digital supply first
    function automatic logic [15:0] mon_mask(int i);
        return 16'h0100 >> i;
    endfunction : mon_mask
    // One channel fault case on a random channel
    task automatic chan_case(asf_func_t f, logic [2:0] d, logic inv,
                             int lim, int hold, logic exp);
        int c;
        c = $unsigned($random(seed)) % ASF_NUM_CH;
        cfg[c] = '{f, 1'b1, inv, 16'(lim)};
        det[c] = asf_chan_det_t'(d);
        step(hold);
        cfg[c] = '0;
        det[c] = '0;
        step(4);
        cmp("alert_flags", exp ? 16'h0001 << c : 16'h0000, {7'h00, flags});
        wreg(ASF_ALERT_ADDR, 16'h000f);
    endtask : chan_case
    task automatic results();
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Watchdog
    initial begin
        step(5000);
        err_total++;
        results();
    end

    // Main sequence
    initial begin
        step(3);
        rst = 1'b0;
        rreg(ASF_ALERT_ADDR, v);
        cmp("reg_rdata", ASF_ALERT_RESET, v);
        for (int i = 0; i < 5; i++) begin
            mon = asf_mon_t'(5'h10 >> i);
            step(2 + $unsigned($random(seed)) % 4);
            mon = '0;
            step(4);
            rreg(ASF_ALERT_ADDR, v);
            cmp("reg_rdata", mon_mask(i), v);
            wreg(ASF_ALERT_ADDR, 16'($random(seed)) & ~mon_mask(i));
            wreg(8'h2f, 16'hffff);
            rreg(8'h2f, v);
            cmp("reg_rdata", 16'h0000, v);
            cmp("alert_flags", mon_mask(i), {7'h00, flags});
            wreg(ASF_ALERT_ADDR, mon_mask(i));
            cmp("alert_flags", 16'h0000, {7'h00, flags});
        end
        // Cause gone at the pin, still in the synchroniser at the clear
        mon.over_temperature = 1'b1;
        step(4);
        mon = '0;
        step(1);
        wreg(ASF_ALERT_ADDR, 16'h0010);
        cmp("alert_flags", 16'h0010, {7'h00, flags});
        rst = 1'b1;
        step(3);
        rst = 1'b0;
        cmp("alert_flags", 16'h0000, {7'h00, flags});
        n = 3 + $unsigned($random(seed)) % 8;
        chan_case(ASF_FUNC_VOUT, 3'b100, 1'b0, L, L + 2, 1'b0);
        chan_case(ASF_FUNC_VOUT, 3'b100, 1'b0, L, L + 6, 1'b1);
        chan_case(ASF_FUNC_IOUT, 3'b010, 1'b0, L, L + 2, 1'b0);
        chan_case(ASF_FUNC_IOUT, 3'b010, 1'b0, L, L + 3, 1'b1);
        chan_case(ASF_FUNC_IIN_LOOP, 3'b000, 1'b1, n, n + 6, 1'b1);
        chan_case(ASF_FUNC_IIN_LOOP, 3'b000, 1'b0, n, n + 6, 1'b0);
        chan_case(ASF_FUNC_IIN_EXT, 3'b001, 1'b0, n, n + 6, 1'b1);
        chan_case(ASF_FUNC_IIN_EXT, 3'b001, 1'b1, n, n + 6, 1'b0);
        chan_case(ASF_FUNC_VIN, 3'b111, 1'b0, L, L + 6, 1'b0);
        results();
    end
endmodule : asf_alert_flags_tb
